// [rtl/mfpin_pkg.sv]
package mfpin_pkg;

    // Per-pin routing selector codes
    localparam logic [3:0] SEL_NONE     = 4'h0;
    localparam logic [3:0] SEL_PCI_INT  = 4'h1;
    localparam logic [3:0] SEL_IRQ      = 4'h2;
    localparam logic [3:0] SEL_DMA_REQ  = 4'h3;
    localparam logic [3:0] SEL_DMA_GNT  = 4'h4;
    localparam logic [3:0] SEL_LED      = 4'h5;
    localparam logic [3:0] SEL_EVT_REQ  = 4'h6;
    localparam logic [3:0] SEL_EVT_GNT  = 4'h7;
    localparam logic [3:0] SEL_RING     = 4'h8;
    localparam logic [3:0] SEL_VIDEO    = 4'h9;

    localparam int          NUM_PINS    = 8;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;

    // Pin indices with fixed functions
    localparam int PIN_INTA = 0;
    localparam int PIN_INTB = 1;
    localparam int PIN_INTC = 2;
    localparam int PIN_GNT0 = 2;
    localparam int PIN_GNT1 = 3;
    localparam int PIN_REQ0 = 0;
    localparam int PIN_REQ1 = 4;
    localparam int PIN_REQ2 = 7;
    localparam int PIN_RING = 7;

    // Per-pin source levels for routable functions
    typedef struct packed {
        logic [7:0] irq;
        logic [7:0] led;
        logic [7:0] video;
        logic [2:0] pci_int;
        logic       evt_req;
        logic       evt_gnt;
        logic       ring;
        logic       pme;
        logic       dma_req;
    } sources_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

endpackage

// [rtl/mfpin_router.sv]
`timescale 1ns/1ns
// Operation
// - Parallel mode drives INTA on pin 0, INTB pin 1, INTC pin 2.
// - After reset pins 0 to 2 are inputs and do not drive until a route selects an output function.
// - Serial interrupt output carries legacy IRQs, optionally PCI interrupts.
// - Each pin outputs the function its routing field selects where pin and mode allow it, except SEL_EVT_GNT and SEL_DMA_GNT, which leave the pin undriven.
// - A pin with secondary function enabled is not driven by the router.
// - Dedicated ring/PME output; ring may alternatively route to pin 7.
// - Device drives DMA request; controller answers on DMA grant.
// - DMA grant taken from pin 2 or pin 3 as configured.
// - DMA request presented on pin 7, pin 4 or pin 0 as configured.
// - EEPROM and DMA handshakes never own the same pin together.
// - After reset pins 4 and 5 are high-impedance inputs.
module mfpin_router (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    // Configuration
    input  wire logic [31:0]           route_cfg,
    input  wire logic [7:0]            secondary_en,
    input  wire logic                  parallel_pci,
    input  wire logic                  serial_pci_en,
    input  wire logic                  ring_on_pin7,
    input  wire logic                  eeprom_active,
    // Function sources
    input  wire mfpin_pkg::sources_t   src,
    input  wire logic [15:0]           serial_slots,
    // Multifunction pins
    input  wire logic [7:0]            multi_pin_in,
    output logic [7:0]                 multi_pin_out,
    output logic [7:0]                 multi_pin_oe,
    // Dedicated terminals
    output logic [18:0]                serial_irq_line,
    output logic                       ring_indicate_output,
    output logic                       dma_grant_in,
    output logic [7:0]                 gp_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Route register and input synchronisers
    logic [31:0] route;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  sync3;
    logic [7:0]  pin_level;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            route <= mfpin_pkg::ROUTE_RESET;
        end else if (clk_en) begin
            route <= route_cfg;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end else if (clk_en) begin
            sync1 <= multi_pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Accept a change once second and third stages agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_level <= 8'h00;
        end else if (clk_en) begin
            pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin selection
    logic [7:0] next_out;
    logic [7:0] next_oe;
    logic [7:0] is_gnt;

    genvar i;
    generate
        for (i = 0; i < mfpin_pkg::NUM_PINS; i++) begin : g_pin
            wire [3:0] sel     = route[4*i +: 4];
            wire       req_ok  = (i == mfpin_pkg::PIN_REQ0) || (i == mfpin_pkg::PIN_REQ1)
                                 || (i == mfpin_pkg::PIN_REQ2);
            wire       gnt_ok  = (i == mfpin_pkg::PIN_GNT0) || (i == mfpin_pkg::PIN_GNT1);
            wire       int_ok  = (i <= mfpin_pkg::PIN_INTC) && parallel_pci;
            wire       ring_ok = (i == mfpin_pkg::PIN_RING) && ring_on_pin7;
            wire       dma_pin = (req_ok && sel == mfpin_pkg::SEL_DMA_REQ)
                                 || (gnt_ok && sel == mfpin_pkg::SEL_DMA_GNT);
            wire       owned   = secondary_en[i] || (eeprom_active && dma_pin);
            logic      drv;
            logic      val;
            always_comb begin
                drv = 1'b1;
                val = 1'b0;
                unique case (sel)
                    mfpin_pkg::SEL_PCI_INT: begin
                        drv = int_ok;
                        val = (i <= mfpin_pkg::PIN_INTC) ? src.pci_int[i % 3] : 1'b0;
                    end
                    mfpin_pkg::SEL_IRQ:     val = src.irq[i];
                    mfpin_pkg::SEL_DMA_REQ: begin
                        drv = req_ok;
                        val = src.dma_req;
                    end
                    mfpin_pkg::SEL_LED:     val = src.led[i];
                    mfpin_pkg::SEL_EVT_REQ: val = src.evt_req;
                    mfpin_pkg::SEL_RING: begin
                        drv = ring_ok;
                        val = src.ring;
                    end
                    mfpin_pkg::SEL_VIDEO:   val = src.video[i];
                    default:                drv = 1'b0;
                endcase
            end
            assign next_oe[i]  = drv && !owned;
            assign next_out[i] = val && drv && !owned;
            assign is_gnt[i]   = gnt_ok && sel == mfpin_pkg::SEL_DMA_GNT && !owned;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin and terminal outputs
    wire       grant_sel = |(is_gnt & pin_level);
    wire [2:0] ser_pci   = serial_pci_en ? src.pci_int : 3'h0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            multi_pin_out        <= 8'h00;
            multi_pin_oe         <= 8'h00;
            serial_irq_line      <= 19'h00000;
            ring_indicate_output <= 1'b0;
            dma_grant_in         <= 1'b0;
            gp_in                <= 8'h00;
        end else if (clk_en) begin
            multi_pin_out        <= next_out;
            multi_pin_oe         <= next_oe;
            serial_irq_line      <= {ser_pci, serial_slots};
            ring_indicate_output <= (src.ring && !ring_on_pin7) || src.pme;
            dma_grant_in         <= grant_sel;
            gp_in                <= pin_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_no_drive_reset;
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |-> multi_pin_oe == 8'h00;
    endproperty
    a_no_drive_reset: assert property (p_no_drive_reset) else $error("pins drive at reset");

    property p_secondary_off;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && secondary_en[0]) |=> !multi_pin_oe[0];
    endproperty
    a_secondary_off: assert property (p_secondary_off) else $error("secondary pin driven");

    property p_unassigned_off;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && route[3:0] == mfpin_pkg::SEL_NONE) |=> !multi_pin_oe[0];
    endproperty
    a_unassigned_off: assert property (p_unassigned_off) else $error("idle pin driven");

    property p_eeprom_excl;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && eeprom_active && route[31:28] == mfpin_pkg::SEL_DMA_REQ)
            |=> !multi_pin_oe[7];
    endproperty
    a_eeprom_excl: assert property (p_eeprom_excl) else $error("shared pin contention");

    property p_req_pins;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && route[7:4] == mfpin_pkg::SEL_DMA_REQ) |=> !multi_pin_oe[1];
    endproperty
    a_req_pins: assert property (p_req_pins) else $error("request on bad pin");

    property p_inta;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && parallel_pci && route[3:0] == mfpin_pkg::SEL_PCI_INT && !secondary_en[0])
            |=> multi_pin_oe[0] && multi_pin_out[0] == $past(src.pci_int[0]);
    endproperty
    a_inta: assert property (p_inta) else $error("INTA not routed");

    property p_ring;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && src.pme) |=> ring_indicate_output;
    endproperty
    a_ring: assert property (p_ring) else $error("event output missing");

    property p_serial_pci;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && !serial_pci_en) |=> serial_irq_line[18:16] == 3'h0;
    endproperty
    a_serial_pci: assert property (p_serial_pci) else $error("PCI ints in stream");

    property p_serial_slots;
        @(posedge mclk) disable iff (!resetn)
        clk_en |=> serial_irq_line[15:0] == $past(serial_slots);
    endproperty
    a_serial_slots: assert property (p_serial_slots) else $error("IRQ slots not carried");

    property p_irq_route;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && route[23:20] == mfpin_pkg::SEL_IRQ && !secondary_en[5])
            |=> multi_pin_oe[5] && multi_pin_out[5] == $past(src.irq[5]);
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("IRQ not on pin 5");

    property p_ring_pin7;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && ring_on_pin7 && route[31:28] == mfpin_pkg::SEL_RING && !secondary_en[7])
            |=> multi_pin_oe[7] && multi_pin_out[7] == $past(src.ring);
    endproperty
    a_ring_pin7: assert property (p_ring_pin7) else $error("ring not on pin 7");

    property p_grant_taken;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && route[11:8] == mfpin_pkg::SEL_DMA_GNT && !secondary_en[2] && !eeprom_active
            && pin_level[2]) |=> dma_grant_in;
    endproperty
    a_grant_taken: assert property (p_grant_taken) else $error("grant not taken");

    property p_grant_pin_idle;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && route[15:12] == mfpin_pkg::SEL_DMA_GNT) |=> !multi_pin_oe[3];
    endproperty
    a_grant_pin_idle: assert property (p_grant_pin_idle) else $error("grant pin driven");

endmodule

// [verif/dma_ctrl_model.sv]
`timescale 1ns/1ns
module dma_ctrl_model #(
    parameter int LAT = 2
) (
    // Handshake
    input  wire logic mclk,
    input  wire logic req,
    output logic      grant
);
    int   cnt     = 0;
    logic granted = 1'b0;
    // Grant once request held LAT cycles, dropped with it
    always @(posedge mclk) begin
        cnt     <= req ? cnt + 1 : 0;
        granted <= req && cnt >= LAT;
    end
    assign grant = granted;
endmodule

// [verif/interrupt_dma_pin_routing_test.sv]
`timescale 1ns/1ns
module interrupt_dma_pin_routing_test;
    typedef struct packed {
        logic [7:0]  oe;
        logic [7:0]  out;
        logic [18:0] ser;
        logic        ring;
        logic        gv;
        logic        gnt;
        logic [7:0]  gp;
    } exp_t;
    logic mclk = 0, resetn = 0, clk_en = 1, parallel_pci = 0, serial_pci_en = 0;
    logic ring_on_pin7 = 0, eeprom_active = 0, grant, ring_indicate_output, dma_grant_in;
    logic [31:0] route_cfg = 32'h0;
    logic [7:0] secondary_en = 8'h0, ext = 8'h0, multi_pin_out, multi_pin_oe, gp_in;
    logic [15:0] serial_slots = 16'h0;
    logic [18:0] serial_irq_line;
    mfpin_pkg::sources_t src = '0;
    wire [7:0] pads = {ext[7:4], grant, grant, ext[1:0]};
    wire [7:0] multi_pin_in = (multi_pin_out & multi_pin_oe) | (pads & ~multi_pin_oe);
    exp_t q[$];
    exp_t e;
    exp_t last;
    int seed = 12, miscompares = 0, checks = 0;
    event smp;

    mfpin_router mfpin_router_i (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
        .route_cfg(route_cfg), .secondary_en(secondary_en), .parallel_pci(parallel_pci),
        .serial_pci_en(serial_pci_en), .ring_on_pin7(ring_on_pin7),
        .eeprom_active(eeprom_active), .src(src), .serial_slots(serial_slots),
        .multi_pin_in(multi_pin_in), .multi_pin_out(multi_pin_out),
        .multi_pin_oe(multi_pin_oe), .serial_irq_line(serial_irq_line),
        .ring_indicate_output(ring_indicate_output), .dma_grant_in(dma_grant_in),
        .gp_in(gp_in));
    dma_ctrl_model dma_ctrl_model_i (.mclk(mclk), .req(multi_pin_out[7] & multi_pin_oe[7]),
        .grant(grant));

    always #20 mclk = ~mclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic exp_t model();
        exp_t x;
        logic d;
        logic v;
        x = '0;
        for (int p = 0; p < 8; p++) begin
            d = 1'b1;
            v = 1'b0;
            case (route_cfg[4*p +: 4])
                mfpin_pkg::SEL_PCI_INT: begin
                    d = parallel_pci && p < 3;
                    v = src.pci_int[p % 3];
                end
                mfpin_pkg::SEL_IRQ: v = src.irq[p];
                mfpin_pkg::SEL_DMA_REQ: begin
                    d = !eeprom_active && (p == 0 || p == 4 || p == 7);
                    v = src.dma_req;
                end
                mfpin_pkg::SEL_LED: v = src.led[p];
                mfpin_pkg::SEL_EVT_REQ: v = src.evt_req;
                mfpin_pkg::SEL_RING: begin
                    d = ring_on_pin7 && p == 7;
                    v = src.ring;
                end
                mfpin_pkg::SEL_VIDEO: v = src.video[p];
                default: d = 1'b0;
            endcase
            x.oe[p] = d && !secondary_en[p];
            x.out[p] = x.oe[p] & v;
        end
        x.ser = {serial_pci_en ? src.pci_int : 3'h0, serial_slots};
        x.ring = (src.ring & !ring_on_pin7) | src.pme;
        return x;
    endfunction

    task automatic note(input exp_t x);
        last = x;
        q.push_back(x);
        -> smp;
    endtask

    task automatic apply(input int n, input logic gv, input logic gnt);
        exp_t x;
        repeat (n) @(negedge mclk);
        x = model();
        x.gv = gv;
        x.gnt = gnt;
        // Undriven pins show the pads, grant pads at the expected grant level
        x.gp = (x.out & x.oe) | ({ext[7:4], gnt, gnt, ext[1:0]} & ~x.oe);
        note(x);
    endtask

    always @(smp) begin
        e = q.pop_front();
        check(32'(multi_pin_oe), 32'(e.oe));
        check(32'(multi_pin_out & e.oe), 32'(e.out));
        check(32'(serial_irq_line), 32'(e.ser));
        check(32'(ring_indicate_output), 32'(e.ring));
        if (e.gv) check(32'(dma_grant_in), 32'(e.gnt));
        if (e.gv) check(32'(gp_in), 32'(e.gp));
    end

    initial begin
        exp_t x;
        apply(14, 1'b0, 1'b0);
        repeat (2) @(negedge mclk);
        resetn = 1;
        apply(2, 1'b0, 1'b0);
        for (int r = 0; r < 3; r++)
            for (int p = 0; p < 8; p++)
                for (int c = 0; c < 10; c++) begin
                    route_cfg = $random(seed);
                    route_cfg[4*p +: 4] = c[3:0];
                    {parallel_pci, serial_pci_en, ring_on_pin7, eeprom_active} = 4'($random(seed));
                    secondary_en = 8'($random(seed) & $random(seed));
                    src = $random(seed);
                    serial_slots = 16'($random(seed));
                    ext = 8'($random(seed));
                    apply(5, 1'b0, 1'b0);
                end
        // Request on pin 7, grant back on pin 2 then pin 3
        for (int g = 2; g < 4; g++) begin
            {parallel_pci, serial_pci_en, ring_on_pin7, eeprom_active} = 4'h0;
            secondary_en = 8'h0;
            route_cfg = 32'h3000_0000 | (32'h4 << (4 * g));
            src = '0;
            src.dma_req = 1'b1;
            apply(14, 1'b1, 1'b1);
            src.dma_req = 1'b0;
            apply(14, 1'b1, 1'b0);
        end
        // Routed pins let go in reset and stay off until the route is retaken
        {parallel_pci, serial_pci_en, ring_on_pin7, eeprom_active} = 4'h0;
        secondary_en = 8'h00;
        route_cfg = 32'h0022_2222;
        src = $random(seed);
        apply(5, 1'b0, 1'b0);
        @(negedge mclk);
        resetn = 0;
        repeat (2) @(negedge mclk);
        note('0);
        resetn = 1;
        @(negedge mclk);
        x = model();
        x.oe = 8'h00;
        x.out = 8'h00;
        note(x);
        apply(1, 1'b0, 1'b0);
        // Clock enable low holds the pin, serial and ring outputs
        clk_en = 0;
        route_cfg = ~route_cfg;
        src = $random(seed);
        serial_slots = 16'($random(seed));
        repeat (4) @(negedge mclk);
        note(last);
        clk_en = 1;
        apply(5, 1'b0, 1'b0);
        @(negedge mclk);
        report_and_stop();
    end

    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end
endmodule
